//--- verilog/vhs_header_stats.sv
// Purpose: Compressed header element walker, symbol FIFO, statistics counters, table tail.
// Assumes: Element, diff and statistic inputs come from logic on CLOCK.
// Notes:   Counter increments are ignored while counters clear or stream out.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Symbol FIFO
// ----------------------------------------------------------------
module vhs_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 32
) (
	input  wire logic         CLOCK,
	input  wire logic         SYS_RST,
	input  wire logic         IN_VALID,
	output logic              IN_READY,
	input  wire logic [W-1:0] IN_DATA,
	output logic              OUT_VALID,
	input  wire logic         OUT_READY,
	output logic [W-1:0]      OUT_DATA
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} vhs_fifo_state_t;
	vhs_fifo_state_t s_q, s_d;
	logic [W-1:0]    mem [DEPTH];
	logic            full, empty;

	// Pointer compare with wrap bit
	assign empty     = (s_q.wp == s_q.rp);
	assign full      = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
	assign IN_READY  = !full;
	assign OUT_VALID = !empty;
	assign OUT_DATA  = mem[s_q.rp[AW-1:0]];

	// Pointer advance
	always_comb begin
		s_d = s_q;
		if (IN_VALID && !full)
			s_d.wp = s_q.wp + 1'b1;
		if (OUT_READY && !empty)
			s_d.rp = s_q.rp + 1'b1;
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Storage
	always_ff @(posedge CLOCK) begin
		if (IN_VALID && !full)
			mem[s_q.wp[AW-1:0]] <= IN_DATA;
	end
endmodule : vhs_fifo

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module vhs_header_stats #(
	parameter int FIFO_DEPTH = vhs_pkg::SYM_FIFO_DEPTH
) (
	input  wire logic                          CLOCK,
	input  wire logic                          SYS_RST,
	input  wire logic [7:0]                    S_AXI_AWADDR,
	input  wire logic                          S_AXI_AWVALID,
	output logic                               S_AXI_AWREADY,
	input  wire logic [31:0]                   S_AXI_WDATA,
	input  wire logic [3:0]                    S_AXI_WSTRB,
	input  wire logic                          S_AXI_WVALID,
	output logic                               S_AXI_WREADY,
	output logic [1:0]                         S_AXI_BRESP,
	output logic                               S_AXI_BVALID,
	input  wire logic                          S_AXI_BREADY,
	input  wire logic [7:0]                    S_AXI_ARADDR,
	input  wire logic                          S_AXI_ARVALID,
	output logic                               S_AXI_ARREADY,
	output logic [31:0]                        S_AXI_RDATA,
	output logic [1:0]                         S_AXI_RRESP,
	output logic                               S_AXI_RVALID,
	input  wire logic                          S_AXI_RREADY,
	input  wire logic [3:0]                    ELEM_DATA,
	input  wire logic                          ELEM_VALID,
	output logic                               ELEM_READY,
	input  wire logic [7:0]                    DIFF_DATA,
	input  wire logic                          DIFF_VALID,
	output logic                               DIFF_READY,
	output logic [vhs_pkg::SYM_W-1:0]          SYM_DATA,
	output logic                               SYM_VALID,
	input  wire logic                          SYM_READY,
	input  wire logic                          STAT_INC,
	input  wire logic [vhs_pkg::CTX_W-1:0]     STAT_CTX,
	output logic [31:0]                        LINE_ADDR,
	output logic [vhs_pkg::LINE_W-1:0]         LINE_DATA,
	output logic                               LINE_VALID,
	input  wire logic                          LINE_READY
);
	import vhs_pkg::*;

	typedef struct packed {
		vhs_phase_t  phase;
		logic [12:0] elem_cnt;
		logic [10:0] diff_cnt;
		logic [11:0] sweep;
		logic [7:0]  line_idx;
		logic [31:0] line_addr;
		logic [LINE_W-1:0] line;
		logic        err;
		logic        inc_lost;
		logic [31:0] base;
		logic [11:0] tbl_idx;
		logic        aw_have;
		logic [7:0]  awaddr;
		logic        w_have;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} vhs_state_t;

	vhs_state_t       s_q, s_d;
	logic [CNT_W-1:0] cnt_mem [CNT_TOTAL];
	logic             mem_we;
	logic [CTX_W-1:0] mem_addr;
	logic [CNT_W-1:0] mem_wd;
	logic             need_diff, elem_take, diff_take, push, fifo_in_ready, inc_ok;
	logic [SYM_W-1:0] sym_in;
	logic [7:0]       tbl_byte;

	// ----------------------------------------------------------------
	// Default table tail lookup
	// ----------------------------------------------------------------
	function automatic logic [7:0] table_lookup(input logic [11:0] idx);
		logic [11:0] rel;
		rel = idx - CHROMA_BASE;
		if (idx >= CHROMA_BASE && idx < SEG_BASE)
			return CHROMA_DEFAULTS[rel[6:0]];
		else if (idx >= SEG_BASE && idx < SEG_END)
			return SEG_DEFAULT;
		else
			return 8'h00;
	endfunction : table_lookup

	assign tbl_byte = table_lookup(s_q.tbl_idx);

	// Byte lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return merge_out(r);
	endfunction : merge

	function automatic logic [31:0] merge_out(input logic [31:0] v);
		return v;
	endfunction : merge_out

	// ----------------------------------------------------------------
	// Element walker
	// ----------------------------------------------------------------
	// Kind-0 elements own a diff slot even when skipped, keeping alignment
	assign need_diff  = !ELEM_DATA[ELEM_KIND_BIT] && (s_q.diff_cnt < DIFF_TOTAL);
	assign elem_take  = (s_q.phase == PH_HDR) && ELEM_VALID && fifo_in_ready && (!need_diff || DIFF_VALID);
	assign diff_take  = (elem_take && need_diff) || ((s_q.phase == PH_DRAIN) && DIFF_VALID);
	assign push       = elem_take && ELEM_DATA[ELEM_VALID_BIT] && (ELEM_DATA[ELEM_KIND_BIT] || need_diff);
	assign ELEM_READY = elem_take;
	assign DIFF_READY = diff_take;

	// Symbol word: bin with fixed probability, or the raw diff byte
	always_comb begin
		if (ELEM_DATA[ELEM_KIND_BIT])
			sym_in = {1'b0, ELEM_DATA[ELEM_BIN_BIT], ELEM_DATA[ELEM_PROB_BIT] ? PROB_HIGH : PROB_LOW};
		else
			sym_in = {1'b1, 1'b0, DIFF_DATA};
	end

	vhs_fifo #(
		.W     (SYM_W),
		.DEPTH (FIFO_DEPTH)
	) u_sym_fifo (
		.CLOCK     (CLOCK),
		.SYS_RST   (SYS_RST),
		.IN_VALID  (push),
		.IN_READY  (fifo_in_ready),
		.IN_DATA   (sym_in),
		.OUT_VALID (SYM_VALID),
		.OUT_READY (SYM_READY),
		.OUT_DATA  (SYM_DATA)
	);

	// ----------------------------------------------------------------
	// Counter memory port
	// ----------------------------------------------------------------
	assign inc_ok = STAT_INC && (STAT_CTX < CNT_TOTAL) &&
		(s_q.phase != PH_CLEAR) && (s_q.phase != PH_FILL) && (s_q.phase != PH_OFFER);

	// Sweep writes zero; otherwise one increment per cycle
	always_comb begin
		mem_we   = 1'b0;
		mem_addr = STAT_CTX;
		mem_wd   = cnt_mem[STAT_CTX] + 32'h0000_0001;
		if (s_q.phase == PH_CLEAR || s_q.phase == PH_FILL) begin
			mem_we   = 1'b1;
			mem_addr = s_q.sweep;
			mem_wd   = '0;
		end else if (inc_ok) begin
			mem_we = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (mem_we)
			cnt_mem[mem_addr] <= mem_wd;
	end

	// ----------------------------------------------------------------
	// Sequencing and register bus
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (STAT_INC && !inc_ok)
			s_d.inc_lost = 1'b1;
		unique case (s_q.phase)
			PH_CLEAR: begin
				s_d.sweep = s_q.sweep + 12'd1;
				if (s_q.sweep == CNT_TOTAL - 12'd1) begin
					s_d.sweep = '0;
					s_d.phase = PH_IDLE;
				end
			end
			PH_IDLE: ;
			PH_HDR: begin
				if (diff_take)
					s_d.diff_cnt = s_q.diff_cnt + 11'd1;
				if (elem_take && !ELEM_DATA[ELEM_KIND_BIT] && !need_diff && ELEM_DATA[ELEM_VALID_BIT])
					s_d.err = 1'b1;
				if (elem_take) begin
					s_d.elem_cnt = s_q.elem_cnt + 13'd1;
					// Fixed length surface, then drain unused diff slots
					if (s_q.elem_cnt == ELEM_TOTAL - 13'd1)
						s_d.phase = (s_d.diff_cnt < DIFF_TOTAL) ? PH_DRAIN : PH_IDLE;
				end
			end
			PH_DRAIN: begin
				if (diff_take) begin
					s_d.diff_cnt = s_q.diff_cnt + 11'd1;
					if (s_q.diff_cnt == DIFF_TOTAL - 11'd1)
						s_d.phase = PH_IDLE;
				end
			end
			PH_FILL: begin
				// Lane 0 ends in the low word of the line
				s_d.line  = {cnt_mem[s_q.sweep], s_q.line[LINE_W-1:CNT_W]};
				s_d.sweep = s_q.sweep + 12'd1;
				if (s_q.sweep[3:0] == 4'hF)
					s_d.phase = PH_OFFER;
			end
			PH_OFFER: begin
				if (LINE_READY) begin
					s_d.line_idx  = s_q.line_idx + 8'd1;
					s_d.line_addr = s_q.line_addr + LINE_BYTES;
					s_d.phase     = (s_q.line_idx == LINE_TOTAL - 8'd1) ? PH_IDLE : PH_FILL;
				end
			end
		endcase

		// Write channel capture, either order
		if (S_AXI_AWVALID && !s_q.aw_have) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !s_q.w_have) begin
			s_d.w_have = 1'b1;
			s_d.wdata  = S_AXI_WDATA;
			s_d.wstrb  = S_AXI_WSTRB;
		end
		if (s_q.bvalid && S_AXI_BREADY)
			s_d.bvalid = 1'b0;
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = RESP_OKAY;
			unique case ({s_q.awaddr[7:2], 2'b00})
				REG_CTRL: begin
					if (s_q.phase == PH_IDLE && s_q.wstrb[0]) begin
						if (s_q.wdata[CTRL_CLR_BIT]) begin
							s_d.phase = PH_CLEAR;
							s_d.sweep = '0;
						end else if (s_q.wdata[CTRL_HDR_BIT]) begin
							s_d.phase    = PH_HDR;
							s_d.elem_cnt = '0;
							s_d.diff_cnt = '0;
							s_d.err      = 1'b0;
						end else if (s_q.wdata[CTRL_OUT_BIT]) begin
							s_d.phase     = PH_FILL;
							s_d.sweep     = '0;
							s_d.line_idx  = '0;
							s_d.line_addr = {s_q.base[31:6], 6'h00};
							s_d.inc_lost  = 1'b0;
						end
					end
				end
				REG_OUT_BASE:  s_d.base    = merge(s_q.base, s_q.wdata, s_q.wstrb) & 32'hFFFF_FFC0;
				REG_TBL_INDEX: s_d.tbl_idx = 12'(merge({20'h0, s_q.tbl_idx}, s_q.wdata, s_q.wstrb));
				REG_STATUS, REG_ELEM_CNT, REG_DIFF_CNT, REG_LINE_CNT, REG_TBL_DATA: ;
				default:       s_d.bresp   = RESP_SLVERR;
			endcase
		end

		// Read channel, answer one cycle after the address
		if (s_q.rvalid && S_AXI_RREADY)
			s_d.rvalid = 1'b0;
		if (S_AXI_ARVALID && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OKAY;
			unique case ({S_AXI_ARADDR[7:2], 2'b00})
				REG_CTRL:      s_d.rdata = 32'h0000_0000;
				REG_STATUS:    s_d.rdata = {26'h0, s_q.inc_lost, s_q.err, s_q.phase == PH_CLEAR,
					s_q.phase == PH_FILL || s_q.phase == PH_OFFER,
					s_q.phase == PH_HDR || s_q.phase == PH_DRAIN, s_q.phase == PH_IDLE};
				REG_ELEM_CNT:  s_d.rdata = {19'h0, s_q.elem_cnt};
				REG_DIFF_CNT:  s_d.rdata = {21'h0, s_q.diff_cnt};
				REG_LINE_CNT:  s_d.rdata = {24'h0, s_q.line_idx};
				REG_OUT_BASE:  s_d.rdata = s_q.base;
				REG_TBL_INDEX: s_d.rdata = {20'h0, s_q.tbl_idx};
				REG_TBL_DATA:  s_d.rdata = {24'h0, tbl_byte};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_q         <= '0;
			s_q.phase   <= PH_CLEAR;
			s_q.base    <= OUT_BASE_RST;
			s_q.tbl_idx <= TBL_INDEX_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Port drive
	assign S_AXI_AWREADY = !s_q.aw_have;
	assign S_AXI_WREADY  = !s_q.w_have;
	assign S_AXI_BVALID  = s_q.bvalid;
	assign S_AXI_BRESP   = s_q.bresp;
	assign S_AXI_ARREADY = !s_q.rvalid;
	assign S_AXI_RVALID  = s_q.rvalid;
	assign S_AXI_RDATA   = s_q.rdata;
	assign S_AXI_RRESP   = s_q.rresp;
	assign LINE_VALID    = (s_q.phase == PH_OFFER);
	assign LINE_DATA     = s_q.line;
	assign LINE_ADDR     = s_q.line_addr;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic             inc_hit_q;
	logic [CTX_W-1:0] inc_ctx_q;
	logic [CNT_W-1:0] inc_old_q;
	logic [4:0]       gap_q;

	// Cycles since the line output was last valid, saturating
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST)
			gap_q <= '0;
		else if (LINE_VALID)
			gap_q <= '0;
		else if (gap_q != 5'h1F)
			gap_q <= gap_q + 5'h01;
	end

	// Remember each increment for one cycle
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			inc_hit_q <= 1'b0;
			inc_ctx_q <= '0;
			inc_old_q <= '0;
		end else begin
			inc_hit_q <= inc_ok;
			inc_ctx_q <= STAT_CTX;
			inc_old_q <= cnt_mem[STAT_CTX];
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	sequence s_line_taken;
		LINE_VALID && LINE_READY && (s_q.line_idx != LINE_TOTAL - 8'd1);
	endsequence
	sequence s_refill;
		##16 (LINE_VALID && gap_q == 5'h10);
	endsequence

	a_skip_invalid: assert property (elem_take && !ELEM_DATA[ELEM_VALID_BIT] |-> !push)
		else $error("invalid element produced a symbol");
	a_bin_prob: assert property (push && ELEM_DATA[ELEM_KIND_BIT] |-> sym_in[7:0] ==
		(ELEM_DATA[ELEM_PROB_BIT] ? 8'hFC : 8'h80) && sym_in[SYM_BIN_BIT] == ELEM_DATA[ELEM_BIN_BIT])
		else $error("bin symbol has wrong probability or value");
	a_diff_pair: assert property (push && !ELEM_DATA[ELEM_KIND_BIT] |-> diff_take && sym_in[7:0] == DIFF_DATA
		&& sym_in[SYM_DIFF_BIT])
		else $error("diff symbol not paired with diff byte");
	a_elem_limit: assert property (s_q.elem_cnt <= 13'd4033)
		else $error("element count beyond surface length");
	a_diff_limit: assert property (diff_take |-> s_q.diff_cnt < 11'd1805)
		else $error("diff taken beyond surface length");
	a_line_total: assert property (LINE_VALID |-> s_q.line_idx < 8'd193)
		else $error("too many counter lines");
	a_line_addr: assert property (LINE_VALID |-> LINE_ADDR == s_q.base + {18'h0, s_q.line_idx, 6'h00})
		else $error("line address not ascending from base");
	a_line_hold: assert property (LINE_VALID && !LINE_READY |=> LINE_VALID && $stable(LINE_DATA))
		else $error("line dropped before taken");
	a_line_refill: assert property (s_line_taken |=> s_refill)
		else $error("line not refilled in sixteen cycles");
	a_count_inc: assert property (inc_hit_q |-> cnt_mem[inc_ctx_q] == inc_old_q + 32'h0000_0001)
		else $error("counter did not increment");
	a_table_chroma: assert property (s_q.tbl_idx == 12'd1920 |-> tbl_byte == 8'h90)
		else $error("chroma set start misplaced");
	a_table_seg: assert property (s_q.tbl_idx >= 12'd2010 && s_q.tbl_idx < 12'd2017 |-> tbl_byte == 8'hFF)
		else $error("segment tree default wrong");
endmodule : vhs_header_stats

//--- verilog/vhs_pkg.sv
// Purpose: Constants and types for the header stream and statistics block.
// Assumes: One clock, 32-bit register bus, 512-bit counter lines.
// Notes:   Operation
// Operation
// - Diffs are packed bytes in syntax order
// - Elements are 4-bit fields in syntax order
// - Element with cleared valid emits nothing
// - Kind select: bin, else next diff
// - Bin probability 252 or 128 by select
// - Bin value coded with selected probability
// - Element surface fixed at 4033 elements
// - Includes 4 coefficient flags, 5 control fields
// - Counters streamed out after frame, syntax order
// - Sixteen 32-bit counters fill one line
// - 193 line writes per frame
// - One counter per context, counts symbols
// - Chroma sets at 1920, nine bytes each
// - Segment tree: 7 bytes at 2010, 255
package vhs_pkg;
	// ----------------------------------------------------------------
	// Surface geometry
	// ----------------------------------------------------------------
	localparam logic [10:0] DIFF_TOTAL     = 11'd1805;
	localparam int          DIFF_LINES     = 29;
	localparam logic [12:0] ELEM_TOTAL     = 13'd4033;
	localparam int          ELEM_BITS      = 16132;
	localparam int          ELEM_LINES     = 32;
	localparam int          COEF_FLAGS     = 4;
	localparam int          CTRL_FIELDS    = 5;
	localparam int          ELEM_VALID_BIT = 3;
	localparam int          ELEM_KIND_BIT  = 2;
	localparam int          ELEM_PROB_BIT  = 1;
	localparam int          ELEM_BIN_BIT   = 0;
	localparam logic [7:0]  PROB_HIGH      = 8'hFC;
	localparam logic [7:0]  PROB_LOW       = 8'h80;
	localparam int          SYM_W          = 10;
	localparam int          SYM_DIFF_BIT   = 9;
	localparam int          SYM_BIN_BIT    = 8;
	localparam int          SYM_FIFO_DEPTH = 32;
	// ----------------------------------------------------------------
	// Counter streamout
	// ----------------------------------------------------------------
	localparam logic [7:0]  LINE_TOTAL     = 8'd193;
	localparam int          LANES          = 16;
	localparam int          CNT_W          = 32;
	localparam int          LINE_W         = 512;
	localparam logic [31:0] LINE_BYTES     = 32'h0000_0040;
	localparam logic [11:0] CNT_TOTAL      = 12'd3088;
	localparam int          CTX_W          = 12;
	// ----------------------------------------------------------------
	// Default probability table tail
	// ----------------------------------------------------------------
	localparam logic [11:0] CHROMA_BASE    = 12'd1920;
	localparam int          CHROMA_SETS    = 10;
	localparam int          CHROMA_SET_B   = 9;
	localparam logic [11:0] SEG_BASE       = 12'd2010;
	localparam logic [11:0] SEG_END        = 12'd2017;
	localparam logic [7:0]  SEG_DEFAULT    = 8'hFF;
	localparam logic [7:0]  CHROMA_DEFAULTS [0:89] = '{
		8'h90, 8'h0B, 8'h36, 8'h9D, 8'hC3, 8'h82, 8'h2E, 8'h3A, 8'h6C,
		8'h76, 8'h0F, 8'h7B, 8'h94, 8'h83, 8'h65, 8'h2C, 8'h5D, 8'h83,
		8'h71, 8'h0C, 8'h17, 8'hBC, 8'hE2, 8'h8E, 8'h1A, 8'h20, 8'h7D,
		8'h78, 8'h0B, 8'h32, 8'h7B, 8'hA3, 8'h87, 8'h40, 8'h4D, 8'h67,
		8'h71, 8'h09, 8'h24, 8'h9B, 8'h6F, 8'h9D, 8'h20, 8'h2C, 8'hA1,
		8'h74, 8'h09, 8'h37, 8'hB0, 8'h4C, 8'h60, 8'h25, 8'h3D, 8'h95,
		8'h73, 8'h09, 8'h1C, 8'h8D, 8'hA1, 8'hA7, 8'h15, 8'h19, 8'hC1,
		8'h78, 8'h0C, 8'h20, 8'h91, 8'hC3, 8'h8E, 8'h20, 8'h26, 8'h56,
		8'h74, 8'h0C, 8'h40, 8'h78, 8'h8C, 8'h7D, 8'h31, 8'h73, 8'h79,
		8'h66, 8'h13, 8'h42, 8'hA2, 8'hB6, 8'h7A, 8'h23, 8'h3B, 8'h80
	};
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_ELEM_CNT   = 8'h08;
	localparam logic [7:0]  REG_DIFF_CNT   = 8'h0C;
	localparam logic [7:0]  REG_LINE_CNT   = 8'h10;
	localparam logic [7:0]  REG_OUT_BASE   = 8'h14;
	localparam logic [7:0]  REG_TBL_INDEX  = 8'h18;
	localparam logic [7:0]  REG_TBL_DATA   = 8'h1C;
	localparam int          CTRL_HDR_BIT   = 0;
	localparam int          CTRL_OUT_BIT   = 1;
	localparam int          CTRL_CLR_BIT   = 2;
	localparam logic [31:0] OUT_BASE_RST   = 32'h0000_0000;
	localparam logic [11:0] TBL_INDEX_RST  = 12'h000;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [2:0] {PH_CLEAR, PH_IDLE, PH_HDR, PH_DRAIN, PH_FILL, PH_OFFER} vhs_phase_t;
endpackage : vhs_pkg

//--- verilog/vhs_header_stats_dummy_guard.sv
`timescale 1ns/1ps

//--- test/vhs_surface_model.sv
// Purpose: Memory surfaces feeding elements and diffs, sinking symbols and lines.
// Assumes: Handshakes are taken on rising clk.
// Notes:   Sinks stall on a free tick; released data lines show a moving pattern.
`timescale 1ns/1ps
module vhs_surface_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sym_hold,
	input  wire logic       elem_ready,
	input  wire logic       diff_ready,
	output logic [3:0]      elem_data,
	output logic            elem_valid,
	output logic [7:0]      diff_data,
	output logic            diff_valid,
	output logic            sym_ready,
	output logic            line_ready
);
	int         e_q;
	int         d_q;
	logic [3:0] tick_q;
	// Element pattern: bins alternate with diff slots, then with more bins, some skipped
	function automatic logic [3:0] elem_of(input int i);
		if (i % 2) return (i % 4 == 1) ? 4'hF : 4'hC;
		if (i < 3610) return (i % 4 == 0) ? 4'h8 : 4'h0;
		return 4'h4;
	endfunction : elem_of
	// Cursors advance on each taken item
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			e_q <= 0;
			d_q <= 0;
			tick_q <= 4'h0;
		end else begin
			tick_q <= tick_q + 4'h1;
			if (elem_valid && elem_ready) e_q <= e_q + 1;
			if (diff_valid && diff_ready) d_q <= d_q + 1;
		end
	end
	// Fixed-length surfaces, fully populated diffs in order
	assign elem_valid = e_q < 4033;
	assign elem_data  = elem_valid ? elem_of(e_q) : tick_q;
	assign diff_valid = d_q < 1805;
	assign diff_data  = diff_valid ? (d_q[7:0] ^ 8'h5A) : {tick_q, tick_q};
	assign sym_ready  = !sym_hold && tick_q[0];
	assign line_ready = tick_q[1:0] == 2'h0;
endmodule : vhs_surface_model

//--- test/tb_top.sv
// Purpose: Self-checking bench for the header stream and statistics block.
// Assumes: AXI4-Lite register access, surface model on the stream side.
// Notes:   Symbols and lines are checked as they leave the block.
`timescale 1ns/1ps
module tb_top;
	import vhs_pkg::*;
	logic clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic stat_inc = 0, sym_hold = 1, awready, wready, bvalid, arready, rvalid, elem_valid;
	logic elem_ready, diff_valid, diff_ready, sym_valid, sym_ready, line_valid, line_ready;
	logic [7:0] awaddr = 0, araddr = 0, diff_data;
	logic [31:0] wdata = 0, rdata, line_addr, v;
	logic [1:0] bresp, rresp, r;
	logic [3:0] elem_data;
	logic [SYM_W-1:0] sym_data, exp_q[$];
	logic [CTX_W-1:0] stat_ctx = 0;
	logic [LINE_W-1:0] line_data, exp_line;
	logic [11:0] t_idx [6] = '{12'h780, 12'h788, 12'h7D1, 12'h7DA, 12'h7E0, 12'h7E1};
	logic [7:0] t_val [6] = '{8'h90, 8'h6C, 8'h66, 8'hFF, 8'hFF, 8'h00};
	int err_count = 0, n_compared = 0, cyc = 0, n_sym = 0, n_line = 0;
	always #2 clock = ~clock;
	vhs_header_stats #(.FIFO_DEPTH(32)) DUT (.CLOCK(clock), .SYS_RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.ELEM_DATA(elem_data), .ELEM_VALID(elem_valid), .ELEM_READY(elem_ready),
		.DIFF_DATA(diff_data), .DIFF_VALID(diff_valid), .DIFF_READY(diff_ready),
		.SYM_DATA(sym_data), .SYM_VALID(sym_valid), .SYM_READY(sym_ready),
		.STAT_INC(stat_inc), .STAT_CTX(stat_ctx), .LINE_ADDR(line_addr),
		.LINE_DATA(line_data), .LINE_VALID(line_valid), .LINE_READY(line_ready));
	vhs_surface_model MDL (.clk(clock), .rst(rst), .sym_hold(sym_hold), .elem_ready(elem_ready),
		.diff_ready(diff_ready), .elem_data(elem_data), .elem_valid(elem_valid), .diff_data(diff_data),
		.diff_valid(diff_valid), .sym_ready(sym_ready), .line_ready(line_ready));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [LINE_W-1:0] s, input logic [LINE_W-1:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict;
		$display("errors=%0d compared=%0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		bit ga, gw;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		ga = 0;
		gw = 0;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			ga = ga || awready;
			gw = gw || wready;
		end while (!(ga && gw && bvalid));
		r = bresp;
		bready <= 0;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		bit ga;
		@(posedge clock);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		ga = 0;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 0;
			ga = ga || arready;
		end while (!(ga && rvalid));
		v = rdata;
		r = rresp;
		rready <= 0;
	endtask : axr
	task automatic wait_idle;
		do axr(REG_STATUS); while (v[0] !== 1'b1);
	endtask : wait_idle
	task automatic stat(input int c);
		@(posedge clock);
		stat_inc <= 1;
		stat_ctx <= c[11:0];
		@(posedge clock);
		stat_inc <= 0;
	endtask : stat
	function automatic logic [31:0] cnt_of(input int k);
		return (k == 0) ? 32'h1 : (k == 17) ? 32'h2 : (k == 3087) ? 32'h3 : 32'h0;
	endfunction : cnt_of
	// Symbol and line monitors, cycle ceiling
	always @(posedge clock) begin
		cyc++;
		if (elem_valid && elem_ready && elem_data[3])
			exp_q.push_back(elem_data[2] ? {1'b0, elem_data[0], elem_data[1] ? PROB_HIGH : PROB_LOW}
				: {2'b10, diff_data});
		if (sym_valid && sym_ready) begin
			n_sym++;
			chk(sym_data & (sym_data[9] ? 10'h2FF : 10'h3FF), exp_q.pop_front());
		end
		if (line_valid && line_ready) begin
			for (int l = 0; l < 16; l++)
				exp_line[l*32 +: 32] = cnt_of(n_line * 16 + l);
			chk(line_addr, 32'h1000 + n_line * 64);
			chk(line_data, exp_line);
			n_line++;
		end
		if (cyc == 40000) begin
			err_count++;
			give_verdict;
		end
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst <= 0;
		wait_idle;
		axr(REG_OUT_BASE);
		chk(v, OUT_BASE_RST);
		axr(8'h20);
		chk({r, v}, {RESP_SLVERR, 32'h0});
		axw(8'h24, 32'h0);
		chk(r, RESP_SLVERR);
		for (int i = 0; i < 6; i++) begin
			axw(REG_TBL_INDEX, {20'h0, t_idx[i]});
			axr(REG_TBL_DATA);
			chk(v, {24'h0, t_val[i]});
		end
		axw(REG_CTRL, 32'h1);
		repeat (100) @(posedge clock);
		chk(exp_q.size(), 32'h20);
		chk(elem_ready, 1'b0);
		sym_hold <= 0;
		wait_idle;
		for (int i = 0; i < 200 && sym_valid; i++) @(posedge clock);
		chk(n_sym, 32'hB67);
		chk(sym_valid, 1'b0);
		axr(REG_ELEM_CNT);
		chk(v, 32'hFC1);
		axr(REG_DIFF_CNT);
		chk(v, 32'h70D);
		axr(REG_STATUS);
		chk(v[5:0], 6'h01);
		stat(0);
		stat(17);
		stat(17);
		repeat (3) stat(3087);
		stat(3088);
		axw(REG_OUT_BASE, 32'h1000);
		axw(REG_CTRL, 32'h2);
		wait_idle;
		chk(n_line, 32'hC1);
		axr(REG_LINE_CNT);
		chk(v, 32'hC1);
		give_verdict;
	end
endmodule : tb_top
